// file: fll_clk_defs.svh
// Register offsets, field positions, reset values and fixed ratios of the clock unit.
// Assumes inclusion by bare name from the package and the clock generation unit.
`ifndef FLL_CLK_DEFS_SVH
`define FLL_CLK_DEFS_SVH

// ************************************************************
// Register offsets
// ************************************************************
`define ADDR_CLK_SRC_CTRL 2'h0
`define ADDR_OSC_CTRL 2'h1
`define ADDR_TRIM 2'h2
`define ADDR_STATUS 2'h3

// ************************************************************
// Field positions
// ************************************************************
`define CSC_SRC_LSB 6
`define CSC_REF_DIVIDER_SEL_LSB 3
`define CSC_REFSEL_BIT 2
`define CSC_INT_REF_OUT_EN_BIT 1
`define CSC_IRSTOP_BIT 0
`define OSC_BUSDIV_LSB 6
`define OSC_RANGE_BIT 5
`define OSC_GAIN_BIT 4
`define OSC_LOWPWR_BIT 3
`define OSC_TYPE_BIT 2
`define OSC_EXT_REF_OUT_EN_BIT 1
`define OSC_ERSTOP_BIT 0
`define STS_MODE_LSB 2
`define STS_FTRIM_BIT 0

// ************************************************************
// Reset values and constants
// ************************************************************
`define CLK_SRC_CTRL_RESET 8'h04
`define OSC_CTRL_RESET 8'h40
`define TRIM_RESET 8'h80
`define CSC_FORCED_ONES 8'h06
`define SRC_LOOP 2'h0
`define SRC_INT 2'h1
`define SRC_EXT 2'h2
`define SRC_RSVD 2'h3
`define BUS_HALVING 2

`endif

// file: fll_clk_pkg.sv
// Types shared by the clock generation unit.
// Assumes the constants header is on the include path.
`include "fll_clk_defs.svh"

package fll_clk_pkg;

    // ************************************************************
    // Operating modes
    // ************************************************************
    typedef enum logic [6:0] {
        MODE_ENG_INT = 7'h01,
        MODE_ENG_EXT = 7'h02,
        MODE_BYP_INT = 7'h04,
        MODE_BYP_INT_LP = 7'h08,
        MODE_BYP_EXT = 7'h10,
        MODE_BYP_EXT_LP = 7'h20,
        MODE_STOP = 7'h40
    } mode_e;

    // ************************************************************
    // Top-level state
    // ************************************************************
    typedef struct packed {
        logic [7:0] src_ctrl;
        logic [7:0] osc_ctrl;
        logic [7:0] trim;
        logic ftrim;
        logic [7:0] rdata;
        mode_e mode;
        mode_e run_mode;
        logic osc_prev;
        logic dbg_clk;
        logic sys_prev;
        logic bus_clk;
        logic loop_en;
        logic int_en;
        logic ext_en;
        logic int_out;
        logic ext_out;
    } core_s;

endpackage

// file: pow2_clk_divider.sv
// Divides a sampled clock level by two to the power of a select code.
// Assumes the input is synchronous to the core clock and slower than half its rate.
`timescale 1ns/100ps

module pow2_clk_divider #(
    parameter int SEL_W = 3
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic in_i,
    input wire logic [SEL_W-1:0] sel_i,
    output logic out_o
);
    localparam int CNT_W = (1 << SEL_W) - 1;

    typedef struct packed {
        logic prev;
        logic [CNT_W-1:0] cnt;
        logic out;
    } div_s;

    div_s st_r;
    div_s st_nxt;

    // ************************************************************
    // Edge counter; bit n of it runs at 1/2^(n+1) of the input
    // ************************************************************
    always_comb begin
        st_nxt = st_r;
        st_nxt.prev = in_i;
        if (in_i && !st_r.prev) begin
            st_nxt.cnt = st_r.cnt + {{(CNT_W-1){1'b0}}, 1'b1};
        end
        if (sel_i == '0) begin
            st_nxt.out = in_i;
        end else begin
            st_nxt.out = st_nxt.cnt[sel_i - 1'b1];
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign out_o = st_r.out;

    cnt_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (in_i && !st_r.prev) |=> (st_r.cnt == $past(st_r.cnt) + 1'b1))
        else $error("divider count missed an input edge");

endmodule

// file: glitchless_clk_mux.sv
// Source multiplexer that switches only while old and new sources are both low.
// Assumes sources are levels synchronous to the core clock; a stuck-high target delays the switch.
`timescale 1ns/100ps

module glitchless_clk_mux (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [2:0] src_i,
    input wire logic [1:0] req_i,
    input wire logic run_i,
    output logic out_o,
    output logic [1:0] cur_o
);
    typedef struct packed {
        logic [1:0] cur;
        logic run;
        logic out;
    } mux_s;

    mux_s st_r;
    mux_s st_nxt;

    // ************************************************************
    // Switch point
    // ************************************************************
    always_comb begin
        st_nxt = st_r;
        if (!src_i[st_r.cur]) begin
            st_nxt.run = run_i;
            if (!src_i[req_i]) begin
                st_nxt.cur = req_i;
            end
        end
        st_nxt.out = st_nxt.run && src_i[st_nxt.cur];
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign out_o = st_r.out;
    assign cur_o = st_r.cur;

    // The old source may still show high in the cycle before the switch; the switch itself must land low
    no_runt_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_r.cur != $past(st_r.cur)) |-> !st_r.out)
        else $error("source switched while output high");

endmodule

// file: clock_generation_unit.sv
// Clock generation unit: loop reference divider, source select, bus divider, debug and reference clocks.
// Assumes all clock inputs are levels sampled by the core clock; the loop oscillator itself is external.
//
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
`include "fll_clk_defs.svh"

module clock_generation_unit (
    input wire logic CORE_CLK_I,
    input wire logic RST_I,
    input wire logic [1:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire logic STOP_I,
    input wire logic DEBUG_ACTIVE_I,
    input wire logic INT_REF_CLK_I,
    input wire logic EXT_REF_CLK_I,
    input wire logic CTRL_OSC_CLK_I,
    output logic [7:0] RDATA_O,
    output logic SYS_CLK_O,
    output logic BUS_CLK_O,
    output logic LOOP_REF_CLK_O,
    output logic LOOP_EN_O,
    output logic DEBUG_CLK_O,
    output logic INT_REF_CLK_O,
    output logic INT_REF_EN_O,
    output logic EXT_REF_CLK_O,
    output logic EXT_REF_EN_O,
    output logic EXT_REF_STOP_EN_O,
    output logic OSC_HIGH_GAIN_O,
    output logic OSC_HIGH_RANGE_O,
    output logic EXT_REF_TYPE_O,
    output logic [8:0] TRIM_O
);

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic is_int_mode(input fll_clk_pkg::mode_e m);
        is_int_mode = (m == fll_clk_pkg::MODE_ENG_INT) || (m == fll_clk_pkg::MODE_BYP_INT) ||
            (m == fll_clk_pkg::MODE_BYP_INT_LP);
    endfunction

    function automatic logic is_ext_mode(input fll_clk_pkg::mode_e m);
        is_ext_mode = (m == fll_clk_pkg::MODE_ENG_EXT) || (m == fll_clk_pkg::MODE_BYP_EXT) ||
            (m == fll_clk_pkg::MODE_BYP_EXT_LP);
    endfunction

    fll_clk_pkg::core_s st_r;
    fll_clk_pkg::core_s st_nxt;

    logic [1:0] clock_source_sel;
    logic [2:0] ref_divider_sel;
    logic loop_ref_sel;
    logic int_ref_out_en;
    logic int_ref_stop_en;
    logic [1:0] bus_divider_sel;
    logic low_power_sel;
    logic ext_ref_out_en;
    logic ext_ref_stop_en;
    logic [1:0] src_req;
    logic loop_ref_in;
    logic mux_out;
    logic [1:0] clock_mode_status;
    logic sys_div_out;
    logic ref_div_out;

    // ************************************************************
    // Field decode
    // ************************************************************
    assign clock_source_sel = st_r.src_ctrl[`CSC_SRC_LSB +: 2];
    assign ref_divider_sel = st_r.src_ctrl[`CSC_REF_DIVIDER_SEL_LSB +: 3];
    assign loop_ref_sel = st_r.src_ctrl[`CSC_REFSEL_BIT];
    assign int_ref_out_en = st_r.src_ctrl[`CSC_INT_REF_OUT_EN_BIT];
    assign int_ref_stop_en = st_r.src_ctrl[`CSC_IRSTOP_BIT];
    assign bus_divider_sel = st_r.osc_ctrl[`OSC_BUSDIV_LSB +: 2];
    assign low_power_sel = st_r.osc_ctrl[`OSC_LOWPWR_BIT];
    assign ext_ref_out_en = st_r.osc_ctrl[`OSC_EXT_REF_OUT_EN_BIT];
    assign ext_ref_stop_en = st_r.osc_ctrl[`OSC_ERSTOP_BIT];

    // Reserved source code falls back to the loop output
    assign src_req = (clock_source_sel == `SRC_RSVD) ? `SRC_LOOP : clock_source_sel;

    // Loop reference only toggles while the loop is enabled
    assign loop_ref_in = st_r.loop_en && (loop_ref_sel ? INT_REF_CLK_I : EXT_REF_CLK_I);

    // ************************************************************
    // Submodules
    // ************************************************************
    pow2_clk_divider #(
        .SEL_W(3)
    ) ref_div_u (
        .clk_i(CORE_CLK_I),
        .rst_i(RST_I),
        .in_i(loop_ref_in),
        .sel_i(ref_divider_sel),
        .out_o(ref_div_out)
    );

    glitchless_clk_mux src_mux_u (
        .clk_i(CORE_CLK_I),
        .rst_i(RST_I),
        .src_i({EXT_REF_CLK_I, INT_REF_CLK_I, CTRL_OSC_CLK_I}),
        .req_i(src_req),
        .run_i(!STOP_I),
        .out_o(mux_out),
        .cur_o(clock_mode_status)
    );

    pow2_clk_divider #(
        .SEL_W(2)
    ) bus_div_u (
        .clk_i(CORE_CLK_I),
        .rst_i(RST_I),
        .in_i(mux_out),
        .sel_i(bus_divider_sel),
        .out_o(sys_div_out)
    );

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        st_nxt = st_r;

        // Register writes
        if (WR_I) begin
            case (ADDR_I)
                `ADDR_CLK_SRC_CTRL: begin
                    st_nxt.src_ctrl = WDATA_I;
                end
                `ADDR_OSC_CTRL: begin
                    st_nxt.osc_ctrl = WDATA_I;
                end
                `ADDR_TRIM: begin
                    st_nxt.trim = WDATA_I;
                end
                `ADDR_STATUS: begin
                    st_nxt.ftrim = WDATA_I[`STS_FTRIM_BIT];
                end
                default: begin
                    st_nxt.ftrim = st_r.ftrim;
                end
            endcase
        end

        // Read data stands for one cycle only
        st_nxt.rdata = 8'h00;
        if (RD_I) begin
            case (ADDR_I)
                `ADDR_CLK_SRC_CTRL: begin
                    st_nxt.rdata = st_r.src_ctrl | `CSC_FORCED_ONES;
                end
                `ADDR_OSC_CTRL: begin
                    st_nxt.rdata = st_r.osc_ctrl;
                end
                `ADDR_TRIM: begin
                    st_nxt.rdata = st_r.trim;
                end
                `ADDR_STATUS: begin
                    st_nxt.rdata = {4'h0, clock_mode_status, 1'b0, st_r.ftrim};
                end
                default: begin
                    st_nxt.rdata = 8'h00;
                end
            endcase
        end

        // Mode from the live settings; low power is overridden while debugging
        if (STOP_I) begin
            st_nxt.mode = fll_clk_pkg::MODE_STOP;
        end else begin
            case (src_req)
                `SRC_INT: begin
                    st_nxt.mode = (low_power_sel && !DEBUG_ACTIVE_I) ? fll_clk_pkg::MODE_BYP_INT_LP :
                        fll_clk_pkg::MODE_BYP_INT;
                end
                `SRC_EXT: begin
                    st_nxt.mode = (low_power_sel && !DEBUG_ACTIVE_I) ? fll_clk_pkg::MODE_BYP_EXT_LP :
                        fll_clk_pkg::MODE_BYP_EXT;
                end
                default: begin
                    st_nxt.mode = loop_ref_sel ? fll_clk_pkg::MODE_ENG_INT :
                        fll_clk_pkg::MODE_ENG_EXT;
                end
            endcase
        end

        // Mode held from before stop decides which reference may keep running
        if (!STOP_I) begin
            st_nxt.run_mode = st_nxt.mode;
        end

        st_nxt.loop_en = (st_nxt.mode == fll_clk_pkg::MODE_ENG_INT) ||
            (st_nxt.mode == fll_clk_pkg::MODE_ENG_EXT) ||
            (st_nxt.mode == fll_clk_pkg::MODE_BYP_INT) ||
            (st_nxt.mode == fll_clk_pkg::MODE_BYP_EXT);

        // Debug clock: half the oscillator, only with the loop running
        st_nxt.osc_prev = CTRL_OSC_CLK_I;
        if (!st_nxt.loop_en) begin
            st_nxt.dbg_clk = 1'b0;
        end else if (CTRL_OSC_CLK_I && !st_r.osc_prev) begin
            st_nxt.dbg_clk = !st_r.dbg_clk;
        end

        // Bus clock is the system clock halved
        st_nxt.sys_prev = sys_div_out;
        if (sys_div_out && !st_r.sys_prev) begin
            st_nxt.bus_clk = !st_r.bus_clk;
        end

        // Reference enables
        if (STOP_I) begin
            st_nxt.int_en = int_ref_stop_en && (int_ref_out_en || is_int_mode(st_r.run_mode));
            st_nxt.ext_en = ext_ref_stop_en && (ext_ref_out_en || is_ext_mode(st_r.run_mode));
        end else begin
            st_nxt.int_en = int_ref_out_en || is_int_mode(st_nxt.mode);
            st_nxt.ext_en = ext_ref_out_en || is_ext_mode(st_nxt.mode);
        end
        st_nxt.int_out = st_nxt.int_en && int_ref_out_en && INT_REF_CLK_I;
        st_nxt.ext_out = st_nxt.ext_en && ext_ref_out_en && EXT_REF_CLK_I;
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            st_r <= '0;
            st_r.src_ctrl <= `CLK_SRC_CTRL_RESET;
            st_r.osc_ctrl <= `OSC_CTRL_RESET;
            st_r.trim <= `TRIM_RESET;
            st_r.mode <= fll_clk_pkg::MODE_ENG_INT;
            st_r.run_mode <= fll_clk_pkg::MODE_ENG_INT;
            st_r.loop_en <= 1'b1;
            st_r.int_en <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ************************************************************
    // Outputs, all from flip-flops
    // ************************************************************
    assign RDATA_O = st_r.rdata;
    assign SYS_CLK_O = sys_div_out;
    assign BUS_CLK_O = st_r.bus_clk;
    assign LOOP_REF_CLK_O = ref_div_out;
    assign LOOP_EN_O = st_r.loop_en;
    assign DEBUG_CLK_O = st_r.dbg_clk;
    assign INT_REF_CLK_O = st_r.int_out;
    assign INT_REF_EN_O = st_r.int_en;
    assign EXT_REF_CLK_O = st_r.ext_out;
    assign EXT_REF_EN_O = st_r.ext_en;
    assign EXT_REF_STOP_EN_O = ext_ref_stop_en;
    assign OSC_HIGH_GAIN_O = st_r.osc_ctrl[`OSC_GAIN_BIT];
    assign OSC_HIGH_RANGE_O = st_r.osc_ctrl[`OSC_RANGE_BIT];
    assign EXT_REF_TYPE_O = st_r.osc_ctrl[`OSC_TYPE_BIT];
    assign TRIM_O = {st_r.trim, st_r.ftrim};

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge CORE_CLK_I);
    endclocking
    default disable iff (RST_I);

    read_forced_a: assert property ((RD_I && ADDR_I == `ADDR_CLK_SRC_CTRL)
        |=> (RDATA_O[2:1] == 2'b11))
        else $error("control bits 1 and 2 did not read as one");

    read_once_a: assert property (!RD_I |=> (RDATA_O == 8'h00))
        else $error("read data stood beyond its cycle");

    reserved_src_a: assert property ((clock_source_sel == `SRC_RSVD) |-> (src_req == `SRC_LOOP))
        else $error("reserved source code not treated as loop");

    ref_select_a: assert property ((st_r.loop_en && !loop_ref_sel) |->
        (loop_ref_in == EXT_REF_CLK_I))
        else $error("loop reference not external when deselected");

    int_out_off_a: assert property (!int_ref_out_en |=> !INT_REF_CLK_O)
        else $error("internal reference output active while disabled");

    stop_int_off_a: assert property ((STOP_I && !int_ref_stop_en) |=> !INT_REF_EN_O)
        else $error("internal reference kept running in stop");

    eng_int_mode_a: assert property ((!STOP_I && src_req == `SRC_LOOP && loop_ref_sel)
        |=> (st_r.mode == fll_clk_pkg::MODE_ENG_INT) && LOOP_EN_O)
        else $error("loop-engaged internal mode not entered");

    lp_no_debug_a: assert property ((!STOP_I && src_req == `SRC_EXT && low_power_sel &&
        !DEBUG_ACTIVE_I) |=> !LOOP_EN_O && !DEBUG_CLK_O)
        else $error("debug clock or loop active in low power bypass");

    stop_quiet_a: assert property ((STOP_I && !LOOP_EN_O) ##1 STOP_I [*3]
        |-> !LOOP_EN_O && !DEBUG_CLK_O)
        else $error("loop or debug clock active in stop");

    debug_half_a: assert property ((st_r.loop_en && LOOP_EN_O && CTRL_OSC_CLK_I &&
        !st_r.osc_prev && !STOP_I && src_req == `SRC_LOOP) |=> (DEBUG_CLK_O != $past(DEBUG_CLK_O)))
        else $error("debug clock missed an oscillator edge");

    bus_half_a: assert property ((sys_div_out && !st_r.sys_prev) |=>
        (BUS_CLK_O != $past(BUS_CLK_O)))
        else $error("bus clock did not toggle on system clock rise");

endmodule

// file: ref_clock_model.sv
// Model of the clock sources around the unit: internal and external reference and loop oscillator.
// Assumes a free-running core clock; every source is a level that changes on its rising edge.
`timescale 1ns/100ps

module ref_clock_model (
    input wire logic clk_i,
    input wire logic rst_i,
    output logic int_ref_o,
    output logic ext_ref_o,
    output logic osc_o
);
    // ************************************************************
    // Sources
    // ************************************************************
    // Periods 8, 6 and 4 core cycles: all at or below 6.25 MHz, slower than half the core rate
    logic [2:0] cnt_r;
    logic [1:0] ext_cnt_r;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_r <= 3'h0;
            ext_cnt_r <= 2'h0;
            ext_ref_o <= 1'b0;
        end else begin
            cnt_r <= cnt_r + 3'h1;
            ext_cnt_r <= (ext_cnt_r == 2'h2) ? 2'h0 : ext_cnt_r + 2'h1;
            if (ext_cnt_r == 2'h2) begin
                ext_ref_o <= ~ext_ref_o;
            end
        end
    end

    assign int_ref_o = cnt_r[2];
    assign osc_o = cnt_r[1];
endmodule

// file: tb_clock_generation_unit.sv
// Self-checking bench for the clock generation unit over its register port.
// Assumes the reference model drives the reference and oscillator clock inputs and edge counts judge the clock paths.
`timescale 1ns/100ps

module tb_clock_generation_unit;
    logic clk, rst, wr, rd, stop, dbg_act, ireff, ereff, osc;
    logic [1:0] addr;
    logic [7:0] wdata, rdata, rv;
    logic sys, bus, lref, loop_en, dbgc, irout, ir_en, erout, er_en, er_stop, gain, rng, etype;
    logic [8:0] trim;
    logic [8:0] probe, prv;
    logic en;
    int c[9];
    int bad_count, checked;

    clock_generation_unit u_clock_generation_unit (.CORE_CLK_I(clk), .RST_I(rst), .ADDR_I(addr),
        .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .STOP_I(stop), .DEBUG_ACTIVE_I(dbg_act),
        .INT_REF_CLK_I(ireff), .EXT_REF_CLK_I(ereff), .CTRL_OSC_CLK_I(osc), .RDATA_O(rdata),
        .SYS_CLK_O(sys), .BUS_CLK_O(bus), .LOOP_REF_CLK_O(lref), .LOOP_EN_O(loop_en),
        .DEBUG_CLK_O(dbgc), .INT_REF_CLK_O(irout), .INT_REF_EN_O(ir_en), .EXT_REF_CLK_O(erout),
        .EXT_REF_EN_O(er_en), .EXT_REF_STOP_EN_O(er_stop), .OSC_HIGH_GAIN_O(gain),
        .OSC_HIGH_RANGE_O(rng), .EXT_REF_TYPE_O(etype), .TRIM_O(trim));
    ref_clock_model u_ref_clock_model (.clk_i(clk), .rst_i(rst), .int_ref_o(ireff), .ext_ref_o(ereff),
        .osc_o(osc));

    // ************************************************************
    // Edge counters
    // ************************************************************
    assign probe = {erout, irout, dbgc, lref, bus, sys, ereff, ireff, osc};
    always @(posedge clk) begin
        if (en) begin
            for (int k = 0; k < 9; k++) begin
                c[k] += int'(probe[k] & ~prv[k]);
            end
        end
        prv <= probe;
    end

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        checked++;
        if (s !== e) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask

    // Edge counts may differ by one through phase at the window ends
    task automatic near(input int a, input int b);
        if (a - b <= 1 && b - a <= 1) chk(16'(a), 16'(a));
        else chk(16'(a), 16'(b));
    endtask

    task automatic wrr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rdr(input logic [1:0] a, output logic [7:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic rdc(input logic [1:0] a, input logic [7:0] e);
        rdr(a, rv);
        chk(16'(rv), 16'(e));
    endtask

    // Window opens after settling and moves on falling edges, clear of the counter
    task automatic m(input int n);
        repeat (4) @(negedge clk);
        for (int k = 0; k < 9; k++) c[k] = 0;
        en = 1'b1;
        repeat (n) @(negedge clk);
        en = 1'b0;
        @(posedge clk);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // ************************************************************
    // Watchdog
    // ************************************************************
    initial begin
        repeat (80000) @(posedge clk);
        bad_count++;
        tally_and_finish();
    end

    // ************************************************************
    // Tests
    // ************************************************************
    initial begin
        rst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 2'h0;
        wdata = 8'h00;
        stop = 1'b0;
        dbg_act = 1'b0;
        en = 1'b0;
        bad_count = 0;
        checked = 0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        #1 chk(16'(loop_en), 16'h0001);
        chk(16'(trim), 16'h0100);
        rdc(2'h0, 8'h06);
        rdc(2'h1, 8'h40);
        rdc(2'h2, 8'h80);
        rdc(2'h3, 8'h00);
        m(512);
        near(c[3], c[0] / 2);
        near(c[6], c[0] / 2);
        for (int i = 0; i < 4; i++) begin
            wrr(2'h1, {2'(i), 6'h00});
            m(512);
            near(c[3], c[0] >> i);
            near(c[4], c[3] / 2);
        end
        wrr(2'h1, 8'h00);
        // Reserved source code must fall back to the loop output
        for (int s = 0; s < 4; s++) begin
            wrr(2'h0, {2'(s), 6'h04});
            repeat (40) @(posedge clk);
            rdc(2'h3, {4'h0, (s == 3) ? 2'h0 : 2'(s), 2'h0});
            m(512);
            near(c[3], c[(s == 3) ? 0 : s]);
        end
        for (int r = 0; r < 8; r++) begin
            wrr(2'h0, {2'h0, 3'(r), 3'h4});
            m(4096);
            near(c[5], c[1] >> r);
        end
        wrr(2'h0, 8'h00);
        m(512);
        near(c[5], c[2]);
        near(c[6], c[0] / 2);
        chk(16'(c[7]), 16'h0000);
        wrr(2'h0, 8'h44);
        m(512);
        near(c[6], c[0] / 2);
        wrr(2'h1, 8'h08);
        m(512);
        chk(16'(loop_en), 16'h0000);
        chk(16'(c[6]), 16'h0000);
        dbg_act <= 1'b1;
        repeat (4) @(posedge clk);
        chk(16'(loop_en), 16'h0001);
        dbg_act <= 1'b0;
        wrr(2'h0, 8'h84);
        m(512);
        near(c[3], c[2]);
        chk(16'(loop_en), 16'h0000);
        wrr(2'h1, 8'h00);
        m(512);
        near(c[3], c[2]);
        near(c[6], c[0] / 2);
        wrr(2'h0, 8'h03);
        m(512);
        near(c[7], c[1]);
        stop <= 1'b1;
        repeat (20) @(posedge clk);
        m(512);
        chk(16'(c[3]), 16'h0000);
        chk(16'(c[6]), 16'h0000);
        chk(16'(loop_en), 16'h0000);
        chk(16'(ir_en), 16'h0001);
        wrr(2'h0, 8'h02);
        repeat (4) @(posedge clk);
        chk(16'(ir_en), 16'h0000);
        stop <= 1'b0;
        wrr(2'h1, 8'h37);
        #1 chk(16'({gain, rng, etype, er_en, er_stop}), 16'h001F);
        m(512);
        near(c[8], c[2]);
        wrr(2'h2, 8'hA5);
        wrr(2'h3, 8'h01);
        #1 chk(16'(trim), 16'h014B);
        tally_and_finish();
    end
endmodule
